/* File: rtl/cants_top.sv */
// apb register slice: abort acks, buffer select, acceptance control, rx error count
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`include "cants_defines.svh"
module cants_top import cants_pkg::*; #(
	parameter int NBUF = `CANTS_NBUF
) (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// transmit engine events, same clock
	input wire logic [2:0] tx_sent,
	input wire logic [2:0] tx_start,
	input wire logic [2:0] tx_failed,
	// receive path, same clock
	input wire logic rx_fg_load,
	input wire logic [2:0] rx_hit_index,
	input wire logic [7:0] rx_err_count,
	input wire logic init_ack_in,
	input wire logic sleep_ack_in,
	// window and mode outputs
	output logic [2:0] tx_window_sel,
	output logic tx_window_open,
	output logic [2:0] abort_request_bit,
	output logic rx_accept_en,
	output logic [1:0] acceptance_mode_field,
	output logic init_request_bit,
	output logic sleep_request_bit
);
	cants_win_if win ();
	cants_win_gate u_gate (.win(win));

	// register state
	logic [2:0] abort_ack_q, abort_ack_d;
	logic [2:0] sel_q, sel_d;
	logic [2:0] empty_q, empty_d;
	logic [2:0] areq_q, areq_d;
	logic [2:0] started_q, started_d;
	logic [1:0] mode_q, mode_d;
	logic [2:0] hit_q, hit_d;
	logic init_request_bit_q, init_request_bit_d, sleep_request_bit_q, sleep_request_bit_d;
	logic init_acknowledge_bit_q, init_acknowledge_bit_d, sleep_acknowledge_bit_q, sleep_acknowledge_bit_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [2:0] wsel_q, wsel_d;
	logic wopen_q, wopen_d;
	logic accept_q, accept_d;
	logic wr_flag, wr_areq, wr_sel, wr_acc, wr_mode;
	cants_bus_state_t bus_q, bus_d;

	// register index from a byte address; off-word addresses give no match
	function automatic logic [7:0] reg_index(input logic [11:0] a);
		reg_index = (a[1:0] == 2'h0) ? a[9:2] : 8'hFF;
	endfunction

	// byte 0 write strobe
	function automatic logic lane0(input logic [3:0] s);
		lane0 = s[0];
	endfunction

	// mode field to filter organisation; closed means nothing reaches the foreground
	function automatic cants_acc_mode_t acc_kind(input logic [1:0] m);
		case (m)
			2'h0: acc_kind = CANTS_ACC_TWO32;
			2'h1: acc_kind = CANTS_ACC_FOUR16;
			2'h2: acc_kind = CANTS_ACC_EIGHT8;
			default: acc_kind = CANTS_ACC_CLOSED;
		endcase
	endfunction

	logic in_init, in_sleep, wr_take, mapped;
	logic [7:0] idx;
	logic [2:0] grant;

	assign win.sel = sel_q;
	assign win.empty = empty_q;
	assign in_init = init_request_bit_q & init_acknowledge_bit_q;
	assign in_sleep = sleep_request_bit_q & sleep_acknowledge_bit_q;
	assign idx = reg_index(paddr);
	// no wait state: taken at the edge that sees the access phase
	assign wr_take = psel & penable & pwrite & (bus_q == CANTS_BUS_ACCESS) & lane0(pstrb);
	// abort granted for queued buffers not started or whose attempt failed
	assign grant = areq_q & ~empty_q & (~started_q | tx_failed); // R19

	// bus phase tracking
	always_comb begin
		bus_d = CANTS_BUS_IDLE;
		case (bus_q)
			CANTS_BUS_IDLE: bus_d = (psel & ~penable) ? CANTS_BUS_ACCESS : CANTS_BUS_IDLE;
			CANTS_BUS_ACCESS: bus_d = CANTS_BUS_IDLE;
			default: bus_d = CANTS_BUS_IDLE;
		endcase
	end

	// address decode for mapped words
	always_comb begin
		if (idx == `CANTS_IDX_ABORT_ACK) begin
			mapped = 1'b1;
		end else if (idx >= `CANTS_IDX_BUF_SEL && idx <= `CANTS_IDX_RX_ERR) begin
			mapped = 1'b1;
		end else if (idx >= `CANTS_IDX_TX_FLAG && idx <= `CANTS_IDX_RX_ERR_SRC) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// write strobes; at most one register is written per access
	always_comb begin
		wr_flag = 1'b0;
		wr_areq = 1'b0;
		wr_sel = 1'b0;
		wr_acc = 1'b0;
		wr_mode = 1'b0;
		if (!wr_take) begin
			wr_flag = 1'b0;
		end else if (idx == `CANTS_IDX_TX_FLAG) begin
			wr_flag = 1'b1;
		end else if (idx == `CANTS_IDX_ABORT_REQ) begin
			wr_areq = 1'b1;
		end else if (idx == `CANTS_IDX_BUF_SEL) begin
			wr_sel = 1'b1;
		end else if (idx == `CANTS_IDX_ACC_CTRL) begin
			wr_acc = 1'b1;
		end else if (idx == `CANTS_IDX_MODE) begin
			wr_mode = 1'b1;
		end
	end

	// transmit flag and abort state
	always_comb begin
		empty_d = empty_q;
		abort_ack_d = abort_ack_q;
		areq_d = areq_q;
		started_d = (started_q | tx_start) & ~tx_failed;
		// software clears empty flags to queue, writing one clears
		if (wr_flag && !in_init) begin
			empty_d = empty_q & ~pwdata[2:0]; // R20
			abort_ack_d = abort_ack_q & ~pwdata[2:0]; // R4
			started_d = started_d & ~pwdata[2:0];
		end
		// a request on an empty buffer has nothing to abort and is dropped
		if (wr_areq && !in_init) begin
			areq_d = areq_q | (pwdata[2:0] & ~empty_q);
		end
		// hardware sets win over a same-cycle clear
		empty_d = empty_d | tx_sent | grant; // R18
		abort_ack_d = (abort_ack_d | grant) & ~tx_sent; // R3
		areq_d = areq_d & ~(tx_sent | grant);
		started_d = started_d & ~(tx_sent | grant);
		// init holds acks and requests at reset
		if (in_init) begin
			abort_ack_d = `CANTS_RST_ABORT_ACK; // R1
			areq_d = 3'h0;
		end
	end

	// buffer select: writes land only with both init bits low
	always_comb begin
		sel_d = sel_q;
		if (wr_sel && !init_request_bit_q && !init_acknowledge_bit_q) begin
			sel_d = pwdata[2:0]; // R9
		end
		// init comes last so it overrides a same-cycle write
		if (in_init) begin
			sel_d = `CANTS_RST_BUF_SEL; // R9
		end
	end

	// acceptance control: mode field and hit index
	always_comb begin
		mode_d = mode_q;
		hit_d = hit_q;
		// mode field writable only in init; hit index never written
		if (wr_acc && in_init) begin
			mode_d = pwdata[`CANTS_ACC_MODE_LSB +: 2]; // R12 R10
		end
		// hit index tracks each foreground load; closed filter never loads
		if (rx_fg_load && acc_kind(mode_q) != CANTS_ACC_CLOSED) begin
			hit_d = rx_hit_index; // R13 R14 R11
		end
	end

	// init and sleep handshake; an ack counts only while its request stands
	always_comb begin
		init_request_bit_d = init_request_bit_q;
		sleep_request_bit_d = sleep_request_bit_q;
		init_acknowledge_bit_d = init_ack_in & init_request_bit_q;
		sleep_acknowledge_bit_d = sleep_ack_in & sleep_request_bit_q;
		// software writes both request bits at once
		if (wr_mode) begin
			init_request_bit_d = pwdata[`CANTS_MODE_INIT_REQUEST_BIT];
			sleep_request_bit_d = pwdata[`CANTS_MODE_SLEEP_REQUEST_BIT];
		end
	end

	// read mux and bus answer
	always_comb begin
		prdata_d = 32'h0000_0000;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (psel && !penable) begin
			pready_d = 1'b1;
			pslverr_d = ~mapped;
		end
		if (psel && !penable && !pwrite) begin
			if (idx == `CANTS_IDX_ABORT_ACK) begin
				prdata_d = {29'h0, abort_ack_q}; // R2
			end else if (idx == `CANTS_IDX_BUF_SEL) begin
				prdata_d = {29'h0, win.onehot}; // R6
			end else if (idx == `CANTS_IDX_ACC_CTRL) begin
				prdata_d = {26'h0, mode_q, 1'b0, hit_q};
			end else if (idx == `CANTS_IDX_TEST_A || idx == `CANTS_IDX_TEST_B) begin
				prdata_d = 32'h0000_0000; // R15
			end else if (idx == `CANTS_IDX_RX_ERR) begin
				// reads zero outside sleep or init, software must not rely on it
				prdata_d = {24'h0, (in_init | in_sleep) ? rx_err_count : 8'h00}; // R16 R17
			end else if (idx == `CANTS_IDX_TX_FLAG) begin
				prdata_d = {29'h0, empty_q};
			end else if (idx == `CANTS_IDX_ABORT_REQ) begin
				prdata_d = {29'h0, areq_q};
			end else if (idx == `CANTS_IDX_MODE) begin
				prdata_d = {28'h0, sleep_acknowledge_bit_q, init_acknowledge_bit_q, sleep_request_bit_q, init_request_bit_q};
			end else if (idx == `CANTS_IDX_RX_ERR_SRC) begin
				prdata_d = {24'h0, rx_err_count};
			end
		end
	end

	// window and filter outputs; flopped so every top port comes from a register
	always_comb begin
		wsel_d = win.onehot;
		wopen_d = win.open;
		accept_d = (acc_kind(mode_d) != CANTS_ACC_CLOSED); // R11
	end

	// bus phase register; clock enable freezes it with everything else
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_q <= CANTS_BUS_IDLE;
		end else if (clk_en) begin
			bus_q <= bus_d;
		end
	end

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (clk_en) begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// transmit flag and abort registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_q <= `CANTS_RST_EMPTY;
			abort_ack_q <= `CANTS_RST_ABORT_ACK;
			areq_q <= 3'h0;
			started_q <= 3'h0;
		end else if (clk_en) begin
			empty_q <= empty_d;
			abort_ack_q <= abort_ack_d;
			areq_q <= areq_d;
			started_q <= started_d;
		end
	end

	// buffer select register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= `CANTS_RST_BUF_SEL;
		end else if (clk_en) begin
			sel_q <= sel_d;
		end
	end

	// acceptance control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `CANTS_RST_ACC_MODE;
			hit_q <= `CANTS_RST_HIT;
		end else if (clk_en) begin
			mode_q <= mode_d;
			hit_q <= hit_d;
		end
	end

	// handshake registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_request_bit_q <= 1'b0;
			sleep_request_bit_q <= 1'b0;
			init_acknowledge_bit_q <= 1'b0;
			sleep_acknowledge_bit_q <= 1'b0;
		end else if (clk_en) begin
			init_request_bit_q <= init_request_bit_d;
			sleep_request_bit_q <= sleep_request_bit_d;
			init_acknowledge_bit_q <= init_acknowledge_bit_d;
			sleep_acknowledge_bit_q <= sleep_acknowledge_bit_d;
		end
	end

	// window and filter output registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wsel_q <= 3'h0;
			wopen_q <= 1'b0;
			accept_q <= 1'b1;
		end else if (clk_en) begin
			wsel_q <= wsel_d;
			wopen_q <= wopen_d;
			accept_q <= accept_d;
		end
	end

	// outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign tx_window_sel = wsel_q;
	assign tx_window_open = wopen_q;
	assign abort_request_bit = areq_q;
	assign rx_accept_en = accept_q;
	assign acceptance_mode_field = mode_q;
	assign init_request_bit = init_request_bit_q;
	assign sleep_request_bit = sleep_request_bit_q;
endmodule

/* File: rtl/cants_defines.svh */
// register offsets, field positions and reset values of the can transmit-select slice
// Overview of operation
// R1: abort acks held reset during init mode
// R2: abort acks readable anytime, writes ignored
// R3: abort ack set only on granted abort
// R4: clearing empty flag clears abort ack
// R5: lowest set select bit picks window buffer
// R6: select readback shows only lowest set bit
// R7: window blocked while selected buffer queued
// R8: no selection means no window access
// R9: select held reset in init, writable outside; code takes writes only with both init bits low
// R10: mode field picks filter organization
// R11: closed filter accepts no message
// R12: acceptance control writable only in init
// R13: hit index names the matching filter
// R14: hit index follows foreground buffer loads
// R15: test registers read zero, ignore writes
// R16: rx error count read-only, valid sleep/init
// R17: software reads error count in sleep/init
// R18: empty flag set on send or abort
// R19: abort granted only before start or failure
// R20: software clears empty flag to queue
`ifndef CANTS_DEFINES_SVH
`define CANTS_DEFINES_SVH
// byte addresses: printed offsets are not all multiples of four, so index times four
`define CANTS_IDX_ABORT_ACK 8'h09
`define CANTS_IDX_BUF_SEL 8'h0A
`define CANTS_IDX_ACC_CTRL 8'h0B
`define CANTS_IDX_TEST_A 8'h0C
`define CANTS_IDX_TEST_B 8'h0D
`define CANTS_IDX_RX_ERR 8'h0E
// own registers for the loose control and status bits
`define CANTS_IDX_TX_FLAG 8'h10
`define CANTS_IDX_ABORT_REQ 8'h11
`define CANTS_IDX_MODE 8'h12
`define CANTS_IDX_RX_ERR_SRC 8'h13
// field positions
`define CANTS_ACC_MODE_LSB 4
`define CANTS_MODE_INIT_REQUEST_BIT 0
`define CANTS_MODE_SLEEP_REQUEST_BIT 1
`define CANTS_MODE_INIT_ACKNOWLEDGE_BIT 2
`define CANTS_MODE_SLEEP_ACKNOWLEDGE_BIT 3
// reset values
`define CANTS_RST_ABORT_ACK 3'h0
`define CANTS_RST_BUF_SEL 3'h0
`define CANTS_RST_EMPTY 3'h7
`define CANTS_RST_ACC_MODE 2'h0
`define CANTS_RST_HIT 3'h0
`define CANTS_NBUF 3
`endif

/* File: rtl/cants_pkg.sv */
// types shared by the can transmit-select slice
package cants_pkg;
	typedef enum logic [3:0] {
		CANTS_ACC_TWO32 = 4'b0001,
		CANTS_ACC_FOUR16 = 4'b0010,
		CANTS_ACC_EIGHT8 = 4'b0100,
		CANTS_ACC_CLOSED = 4'b1000
	} cants_acc_mode_t;
	// access phase tracker of the apb slave
	typedef enum logic [1:0] {
		CANTS_BUS_IDLE = 2'b01,
		CANTS_BUS_ACCESS = 2'b10
	} cants_bus_state_t;
endpackage

/* File: rtl/cants_win_if.sv */
// window-gate signals between the register slice and its window gate
`timescale 1ns/100ps
interface cants_win_if;
	logic [2:0] sel;
	logic [2:0] empty;
	logic [2:0] onehot;
	logic open;
	modport regs (output sel, output empty, input onehot, input open);
	modport gate (input sel, input empty, output onehot, output open);
endinterface

/* File: rtl/cants_win_gate.sv */
// lowest-bit select decoder and access window gate
`timescale 1ns/100ps
module cants_win_gate (
	cants_win_if.gate win
);
	// lowest set bit wins, higher bits ignored
	always_comb begin
		win.onehot = 3'h0;
		if (win.sel[0]) begin
			win.onehot = 3'h1; // R5
		end else if (win.sel[1]) begin
			win.onehot = 3'h2;
		end else if (win.sel[2]) begin
			win.onehot = 3'h4;
		end
	end
	// no selection gives zero and blocks; a queued buffer blocks as well
	assign win.open = |(win.onehot & win.empty); // R7 R8
endmodule

/* File: sim/cants_sva.sv */
// assertions on the ports of the can transmit-select slice
`timescale 1ns/100ps
module cants_sva (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// window and modes
	input wire logic [2:0] tx_window_sel,
	input wire logic tx_window_open,
	input wire logic init_request_bit,
	input wire logic init_ack_in,
	input wire logic [1:0] acceptance_mode_field,
	input wire logic rx_accept_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// init held long enough to flush the lagging select outputs
	sequence s_init;
		(init_request_bit && init_ack_in) [*4];
	endsequence
	property p_rdy;
		psel && !penable |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_wide;
		pready |-> prdata[31:8] == 24'h0;
	endproperty
	a_wide: assert property (p_wide) else $error("upper read bits set");
	property p_hot;
		$onehot0(tx_window_sel);
	endproperty
	a_hot: assert property (p_hot) else $error("two buffers in window");
	property p_nosel;
		tx_window_sel == 3'h0 |-> !tx_window_open;
	endproperty
	a_nosel: assert property (p_nosel) else $error("window open unselected");
	property p_init;
		s_init |=> tx_window_sel == 3'h0;
	endproperty
	a_init: assert property (p_init) else $error("select kept in init");
	property p_closed;
		(acceptance_mode_field == 2'h3) [*2] |-> !rx_accept_en;
	endproperty
	a_closed: assert property (p_closed) else $error("closed filter accepts");
endmodule
bind cants_top cants_sva u_sva (.*);

/* File: sim/cants_engine_model.sv */
// behavioural can engine on the far side of the slice
`timescale 1ns/100ps
module cants_engine_model #(
	parameter logic [7:0] ERRS = 8'h5A
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requests from the slice and the bench
	input wire logic init_request_bit,
	input wire logic sleep_request_bit,
	input wire logic rx_accept_en,
	input wire logic [2:0] snd,
	input wire logic go,
	input wire logic [2:0] hit,
	input wire logic [2:0] strt,
	input wire logic [2:0] fail,
	// engine events
	output logic init_ack_in,
	output logic sleep_ack_in,
	output logic [2:0] tx_sent,
	output logic [2:0] tx_start,
	output logic [2:0] tx_failed,
	output logic rx_fg_load,
	output logic [2:0] rx_hit_index,
	output logic [7:0] rx_err_count
);
	// acks trail requests by a cycle, as a real engine finishing its frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_ack_in <= 1'b0;
			sleep_ack_in <= 1'b0;
			tx_sent <= 3'h0;
			rx_fg_load <= 1'b0;
			rx_hit_index <= 3'h0;
		end else begin
			init_ack_in <= init_request_bit;
			sleep_ack_in <= sleep_request_bit;
			tx_sent <= snd;
			rx_fg_load <= go && rx_accept_en;
			rx_hit_index <= go ? hit : ~rx_hit_index; // stale index never shown
		end
	end
	// start and failure pulses come from the bench so both abort outcomes are reachable
	assign tx_start = strt;
	assign tx_failed = fail;
	assign rx_err_count = ERRS;
endmodule

/* File: sim/tb_can_tx_select_and_filter_ctrl.sv */
// self-checking bench of the can transmit-select slice
`timescale 1ns/100ps
module tb_can_tx_select_and_filter_ctrl;
	localparam logic [7:0] ERR_CNT = 8'h5A;
	logic pclk = 1'b0, presetn, psel, penable, pwrite, go, open_w, acc_en, ir, sr, iak, sak, ld;
	logic pready, pslverr, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [2:0] snd, hit, sent, st, fl, hidx, wsel, areq, stv, flv;
	logic [1:0] mode;
	logic [7:0] rerr;
	logic [11:0] ra [4] = '{12'h024, 12'h028, 12'h02C, 12'h030};
	int err_total = 0;
	int cmp_count = 0;
	always #12.5 pclk = ~pclk;
	cants_top uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_sent(sent), .tx_start(st), .tx_failed(fl),
		.rx_fg_load(ld), .rx_hit_index(hidx), .rx_err_count(rerr), .init_ack_in(iak),
		.sleep_ack_in(sak), .tx_window_sel(wsel), .tx_window_open(open_w),
		.abort_request_bit(areq), .rx_accept_en(acc_en), .acceptance_mode_field(mode),
		.init_request_bit(ir), .sleep_request_bit(sr));
	cants_engine_model #(.ERRS(ERR_CNT)) eng (.pclk(pclk), .presetn(presetn),
		.init_request_bit(ir), .sleep_request_bit(sr), .rx_accept_en(acc_en), .snd(snd),
		.go(go), .hit(hit), .strt(stv), .fail(flv), .init_ack_in(iak), .sleep_ack_in(sak),
		.tx_sent(sent), .tx_start(st), .tx_failed(fl), .rx_fg_load(ld), .rx_hit_index(hidx),
		.rx_err_count(rerr));
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	// one apb transfer; starts one edge on so back-to-back never reassigns psel
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			final_report();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	function automatic logic [2:0] low(input logic [2:0] x);
		return x & (~x + 3'h1);
	endfunction
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		snd = 0;
		go = 0;
		hit = 0;
		stv = 0;
		flv = 0;
		presetn = 0;
		v = $urandom(84285);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, and writes to read-only places leave zero
		foreach (ra[i]) begin
			rdc(ra[i], 32'h0);
			apb(1'b1, 12'h034, $urandom);
			rdc(12'h034, 32'h0);
		end
		apb(1'b1, 12'h024, 32'h7);
		rdc(12'h024, 32'h0);
		// lowest set bit wins in readback and at the window
		repeat (8) begin
			v = $urandom;
			apb(1'b1, 12'h028, v);
			rdc(12'h028, 32'(low(v[2:0])));
			chk(32'(wsel), 32'(low(v[2:0])));
			chk(32'(open_w), 32'(|v[2:0]));
		end
		apb(1'b1, 12'h028, 32'h6);
		rdc(12'h028, 32'h2);
		apb(1'b1, 12'h028, 32'h0);
		rdc(12'h028, 32'h0);
		chk(32'(open_w), 32'h0);
		// queue, abort, requeue, then a real send
		apb(1'b1, 12'h028, 32'h1);
		apb(1'b1, 12'h040, 32'h1);
		@(negedge pclk);
		@(negedge pclk);
		chk(32'(open_w), 32'h0);
		apb(1'b1, 12'h044, 32'h1);
		@(negedge pclk);
		chk(32'(areq), 32'h1);
		rdc(12'h024, 32'h1);
		rdc(12'h040, 32'h7);
		chk(32'(areq), 32'h0);
		apb(1'b1, 12'h040, 32'h1);
		rdc(12'h024, 32'h0);
		snd <= 3'h1;
		@(posedge pclk);
		snd <= 3'h0;
		rdc(12'h040, 32'h7);
		rdc(12'h024, 32'h0);
		apb(1'b1, 12'h040, 32'h2);
		apb(1'b1, 12'h044, 32'h2);
		rdc(12'h024, 32'h2);
		// a started buffer keeps its request until its attempt fails
		apb(1'b1, 12'h040, 32'h4);
		stv <= 3'h4;
		@(posedge pclk);
		stv <= 3'h0;
		apb(1'b1, 12'h044, 32'h4);
		rdc(12'h024, 32'h2);
		chk(32'(areq), 32'h4);
		flv <= 3'h4;
		@(posedge pclk);
		flv <= 3'h0;
		rdc(12'h024, 32'h6);
		rdc(12'h040, 32'h7);
		// init mode: select held at reset, acceptance control writable
		apb(1'b1, 12'h048, 32'h1);
		// the engine's ack trails the request, let init settle first
		repeat (2) @(posedge pclk);
		chk(32'(ir), 32'h1);
		rdc(12'h048, 32'h5);
		rdc(12'h024, 32'h0);
		apb(1'b1, 12'h028, 32'h1);
		rdc(12'h028, 32'h0);
		apb(1'b1, 12'h038, 32'hFF);
		rdc(12'h038, 32'(ERR_CNT));
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h02C, 32'(m << 4) | 32'h7);
			rdc(12'h02C, 32'(m << 4));
			chk(32'(mode), 32'(m));
			chk(32'(acc_en), 32'(m != 3));
		end
		apb(1'b1, 12'h02C, 32'h0);
		// sleep mode: error count still valid, acceptance control locked
		apb(1'b1, 12'h048, 32'h2);
		repeat (2) @(posedge pclk);
		chk(32'(sr), 32'h1);
		chk(32'(ir), 32'h0);
		rdc(12'h038, 32'(ERR_CNT));
		apb(1'b1, 12'h02C, 32'h30);
		rdc(12'h02C, 32'h0);
		apb(1'b1, 12'h048, 32'h0);
		apb(1'b1, 12'h028, 32'h4);
		rdc(12'h028, 32'h4);
		// every filter index reaches the hit field
		for (int h = 0; h < 8; h++) begin
			hit <= 3'(h);
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			rdc(12'h02C, 32'(h));
		end
		rdc(12'h04C, 32'(ERR_CNT));
		apb(1'b0, 12'h050, 32'h0);
		chk(32'(se), 32'h1);
		final_report();
	end
endmodule
